// [design/sysctl_pkg.sv]
/*
 * Constants for the system control and identity register block:
 * register offsets, control field positions, reset value, write mask
 * and access timing counts.
 * Assumes a 40 MHz system clock and a host that reaches the registers
 * over chip select, write enable, output enable and a data bus.
 */
// Notes on behaviour
// - Control bit 0 picks the PLL when one, external source when zero.
// - Control bit 1 enables bus and DMA clocks; reset leaves them off.
// - Control bit 2 set forces the sleep power mode; resets to zero.
// - Control bit 3 set forces the doze power mode; resets to zero.
// - Control bit 4 set stops the PLL oscillator; zero lets it run.
// - Test enables at bits 5, 6, 10, 11 act only in test mode.
// - Bit 9 in test mode floats all output-only pads; else no effect.
// - Bit 7 picks ready handshake or fixed-length access; resets to one.
// - Bit 13 enables the read strobe on DMA reads; resets to zero.
// - Strobe driven low on enabled DMA reads, driven high on other DMA cycles, released when no DMA is active.
// - Identity low byte: silicon revision in 7:4, metal in 3:0.
// - Identity bits 31:8 hold a fixed component identifier code.
`default_nettype none
package sysctl_pkg;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] IDENT_OFS = 8'h04;
    localparam int PLL_SEL_BIT = 0;
    localparam int CLK_GATE_BIT = 1;
    localparam int SLEEP_BIT = 2;
    localparam int DOZE_BIT = 3;
    localparam int OSC_OFF_BIT = 4;
    localparam int SCAN_BIT = 5;
    localparam int CLK_TEST_BIT = 6;
    localparam int READY_BIT = 7;
    localparam int AUDIO_BIT = 8;
    localparam int PAD_FLOAT_BIT = 9;
    localparam int PLL_TEST_BIT = 10;
    localparam int USB_TEST_BIT = 11;
    localparam int STROBE_BIT = 13;
    localparam logic [15:0] CTRL_RESET = 16'h0080;
    localparam logic [15:0] CTRL_WMASK = 16'h2fff;
    localparam int CLK_NS = 25;
    localparam int HANDSHAKE_NS = 75;
    localparam int FIXED_NS = 150;
    localparam int HANDSHAKE_CYC = (HANDSHAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int FIXED_CYC = (FIXED_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_HOLD = 3'b100
    } acc_state_t;
endpackage
`default_nettype wire

// [design/access_timer.sv]
/*
 * Down counter that times one register access.
 * Assumes start is a one-cycle pulse and len is at least one.
 */
`default_nettype none
module access_timer #(
    parameter int W = 4
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic [W-1:0] len,
    output logic done
);
    logic [W-1:0] cnt_ff;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= '0;
        end else if (start) begin
            cnt_ff <= len;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    assign done = (cnt_ff == {{(W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// [design/companion_system_control.sv]
/*
 * System control and identity registers of the companion chip, with
 * the host access sequencer and the DMA read direction strobe.
 * Assumes host pins are synchronous to sys_clk and the chip select is
 * held low until the access has been answered.
 */
`default_nettype none
module companion_system_control
    import sysctl_pkg::*;
#(
    parameter logic [23:0] IDENT_CODE = 24'h5a5a5a, // Arbitrary value
    parameter logic [3:0] SILICON_REV = 4'h1,
    parameter logic [3:0] METAL_REV = 4'h0,
    parameter int TW = 4
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic we_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] data_in,
    output logic [31:0] data_out,
    output logic data_oe,
    output logic rdy,
    input wire logic output_enable_low_in,
    output logic output_enable_low_out,
    output logic output_enable_low_oe,
    input wire logic test_mode,
    input wire logic dma_active,
    input wire logic dma_read,
    output logic pll_select,
    output logic bus_clock_gate,
    output logic dma_clock,
    output logic sleep_request,
    output logic doze_request,
    output logic oscillator_power_down,
    output logic scan_test_gate,
    output logic clock_test_gate,
    output logic pll_test_gate,
    output logic usb_cell_test_gate,
    output logic output_pad_float,
    output logic audio_link_select
);
    localparam logic [TW-1:0] HS_LEN = TW'(HANDSHAKE_CYC);
    localparam logic [TW-1:0] FIX_LEN = TW'(FIXED_CYC);

    acc_state_t state_ff;
    logic [15:0] ctrl_ff;
    logic is_write_ff;
    logic [7:0] addr_ff;
    logic req;
    logic start;
    logic done;
    logic commit;
    logic [31:0] rd_word;

    // A host request is chip select with write enable or output enable low
    assign req = !cs_n && (!we_n || !output_enable_low_in);
    assign start = (state_ff == ST_IDLE) && req && !dma_active;
    assign commit = (state_ff == ST_WAIT) && done;

    access_timer #(
        .W(TW)
    ) u_timer (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .start(start),
        .len(ctrl_ff[READY_BIT] ? HS_LEN : FIX_LEN),
        .done(done)
    );

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (start) begin
                        state_ff <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (done) begin
                        state_ff <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (cs_n) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            is_write_ff <= 1'b0;
            addr_ff <= 8'h00;
        end else if (start) begin
            is_write_ff <= !we_n;
            addr_ff <= addr;
        end
    end

    // Reserved bits are masked so they can never leave zero
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff <= CTRL_RESET;
        end else if (commit && is_write_ff && addr_ff == CTRL_OFS) begin
            ctrl_ff <= data_in[15:0] & CTRL_WMASK;
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        if (addr_ff == CTRL_OFS) begin
            rd_word = {16'h0000, ctrl_ff};
        end else if (addr_ff == IDENT_OFS) begin
            rd_word = {IDENT_CODE, SILICON_REV, METAL_REV};
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            data_out <= 32'h0000_0000;
            data_oe <= 1'b0;
        end else begin
            if (commit && !is_write_ff) begin
                data_out <= rd_word;
            end
            data_oe <= !is_write_ff && !cs_n
                && ((state_ff == ST_HOLD) || commit);
        end
    end

    // Fixed-length mode keeps ready high; the host counts the cycles
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdy <= 1'b1;
        end else if (start && ctrl_ff[READY_BIT]) begin
            rdy <= 1'b0;
        end else if (commit) begin
            rdy <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pll_select <= 1'b0;
            bus_clock_gate <= 1'b0;
            dma_clock <= 1'b0;
            sleep_request <= 1'b0;
            doze_request <= 1'b0;
            oscillator_power_down <= 1'b0;
            audio_link_select <= 1'b0;
        end else begin
            pll_select <= ctrl_ff[PLL_SEL_BIT];
            bus_clock_gate <= ctrl_ff[CLK_GATE_BIT];
            dma_clock <= ctrl_ff[CLK_GATE_BIT];
            sleep_request <= ctrl_ff[SLEEP_BIT];
            doze_request <= ctrl_ff[DOZE_BIT];
            oscillator_power_down <= ctrl_ff[OSC_OFF_BIT];
            audio_link_select <= ctrl_ff[AUDIO_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scan_test_gate <= 1'b0;
            clock_test_gate <= 1'b0;
            pll_test_gate <= 1'b0;
            usb_cell_test_gate <= 1'b0;
            output_pad_float <= 1'b0;
        end else begin
            scan_test_gate <= ctrl_ff[SCAN_BIT] && test_mode;
            clock_test_gate <= ctrl_ff[CLK_TEST_BIT] && test_mode;
            pll_test_gate <= ctrl_ff[PLL_TEST_BIT] && test_mode;
            usb_cell_test_gate <= ctrl_ff[USB_TEST_BIT] && test_mode;
            output_pad_float <= ctrl_ff[PAD_FLOAT_BIT] && test_mode;
        end
    end

    // Strobe is always driven during DMA so transceivers never float
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            output_enable_low_out <= 1'b1;
            output_enable_low_oe <= 1'b0;
        end else begin
            output_enable_low_oe <= dma_active;
            output_enable_low_out <= !(dma_active && dma_read
                && ctrl_ff[STROBE_BIT]);
        end
    end

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence ctrl_write_s;
        commit && is_write_ff && addr_ff == CTRL_OFS;
    endsequence

    sequence handshake_start_s;
        start && ctrl_ff[READY_BIT];
    endsequence

    reserved_bits_a: assert property (
        ctrl_ff[12] == 1'b0 && ctrl_ff[15:14] == 2'b00)
        else $error("Reserved control bit is set");

    ctrl_write_a: assert property (
        ctrl_write_s |=> ctrl_ff == ($past(data_in[15:0]) & CTRL_WMASK))
        else $error("Control write not stored");

    power_modes_a: assert property (
        ctrl_write_s |=> ##1 sleep_request == $past(data_in[2], 2)
            && doze_request == $past(data_in[3], 2)
            && oscillator_power_down == $past(data_in[4], 2)
            && pll_select == $past(data_in[0], 2))
        else $error("Power or clock output does not follow write");

    clock_gate_a: assert property (
        ctrl_write_s ##1 ctrl_ff[CLK_GATE_BIT] |=> bus_clock_gate && dma_clock)
        else $error("Bus clocks not enabled after write");

    test_gate_a: assert property (
        !test_mode |=> !scan_test_gate && !clock_test_gate
            && !pll_test_gate && !usb_cell_test_gate)
        else $error("Test enable active outside test mode");

    pad_float_a: assert property (
        output_pad_float |-> $past(test_mode) && $past(ctrl_ff[PAD_FLOAT_BIT]))
        else $error("Pads floated without test mode and bit set");

    ready_wait_a: assert property (
        handshake_start_s |=> !rdy [*3] ##1 rdy)
        else $error("Ready handshake timing wrong");

    fixed_ready_a: assert property (
        !ctrl_ff[READY_BIT] && state_ff == ST_IDLE |=> rdy)
        else $error("Ready dropped in fixed-length mode");

    strobe_low_a: assert property (
        dma_active && dma_read && ctrl_ff[STROBE_BIT]
            |=> output_enable_low_oe && !output_enable_low_out)
        else $error("Strobe not driven low on DMA read");

    strobe_high_a: assert property (
        dma_active && (!dma_read || !ctrl_ff[STROBE_BIT])
            |=> output_enable_low_oe && output_enable_low_out)
        else $error("Strobe not held high");

    ident_read_a: assert property (
        commit && !is_write_ff && addr_ff == IDENT_OFS
            |=> data_out == {IDENT_CODE, SILICON_REV, METAL_REV})
        else $error("Identity word wrong");
endmodule
`default_nettype wire

// [tb/tb.sv]
/*
 * Self-checking bench for the system control and identity registers.
 * Assumes the design package and design modules are compiled first.
 */
`default_nettype none
module tb;
    import sysctl_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk, rstn, cs_n, we_n, output_enable_low_in;
    logic test_mode, dma_active, dma_read, hs;
    logic [7:0] addr;
    logic [31:0] data_in, data_out, q;
    logic data_oe, rdy, output_enable_low_out, output_enable_low_oe;
    logic pll_select, bus_clock_gate, dma_clock, sleep_request;
    logic doze_request, oscillator_power_down, scan_test_gate;
    logic clock_test_gate, pll_test_gate, usb_cell_test_gate;
    logic output_pad_float, audio_link_select;
    logic [11:0] outs;
    int errors = 0;
    int n_tests = 0;
    // Arbitrary identifier, not any real part code
    localparam logic [23:0] ID = 24'h3c3c3c;
    // Bit 7 cleared in rows 3 to 5 and 7 so fixed-length access is run too
    logic [15:0] row_w [8] = '{16'hffff, 16'hffff, 16'h0001, 16'h0e60,
        16'h0e60, 16'h0182, 16'h001c, 16'h3080};
    logic row_tm [8] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [15:0] row_rd [8] = '{16'h2fff, 16'h2fff, 16'h0001, 16'h0e60,
        16'h0e60, 16'h0182, 16'h001c, 16'h2080};
    logic [11:0] row_o [8] = '{12'hfc1, 12'hfff, 12'h800, 12'h03e,
        12'h000, 12'h601, 12'h1c0, 12'h000};

    assign outs = {pll_select, bus_clock_gate, dma_clock, sleep_request,
        doze_request, oscillator_power_down, scan_test_gate,
        clock_test_gate, pll_test_gate, usb_cell_test_gate,
        output_pad_float, audio_link_select};

    companion_system_control #(.IDENT_CODE(ID), .SILICON_REV(4'h2),
        .METAL_REV(4'h7), .TW(4)) uut (.sys_clk(sys_clk), .rstn(rstn),
        .cs_n(cs_n), .we_n(we_n), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .rdy(rdy),
        .output_enable_low_in(output_enable_low_in),
        .output_enable_low_out(output_enable_low_out),
        .output_enable_low_oe(output_enable_low_oe),
        .test_mode(test_mode), .dma_active(dma_active),
        .dma_read(dma_read), .pll_select(pll_select),
        .bus_clock_gate(bus_clock_gate), .dma_clock(dma_clock),
        .sleep_request(sleep_request), .doze_request(doze_request),
        .oscillator_power_down(oscillator_power_down),
        .scan_test_gate(scan_test_gate),
        .clock_test_gate(clock_test_gate), .pll_test_gate(pll_test_gate),
        .usb_cell_test_gate(usb_cell_test_gate),
        .output_pad_float(output_pad_float),
        .audio_link_select(audio_link_select));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic tick();
        @(posedge sys_clk);
        #2;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request is held until the answer, so data_in stays put past commit
    task automatic access(input logic wr, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] rd);
        int i;
        cs_n = 1'b0;
        we_n = !wr;
        output_enable_low_in = wr;
        addr = a;
        data_in = d;
        if (hs) begin
            for (i = 0; i < 4 && rdy !== 1'b0; i++) tick();
            check(rdy, 1'b0);
            for (i = 0; i < 8 && rdy !== 1'b1; i++) tick();
            check(rdy, 1'b1);
        end else begin
            for (i = 0; i < 8; i++) begin
                tick();
                check(rdy, 1'b1);
            end
        end
        tick();
        rd = data_out;
        check(data_oe, !wr);
        cs_n = 1'b1;
        we_n = 1'b1;
        output_enable_low_in = 1'b1;
        if (wr && a == CTRL_OFS) hs = d[READY_BIT];
        tick();
        check(data_oe, 1'b0);
        tick();
    endtask

    task automatic reset_check();
        check(outs, 12'h000);
        check({rdy, output_enable_low_out, output_enable_low_oe}, 3'b110);
        rstn = 1'b1;
        hs = 1'b1;
        tick();
        access(1'b0, CTRL_OFS, 32'h0, q);
        check(q, 32'h0000_0080);
    endtask

    task automatic strobe(input logic act, input logic rd, input logic oe,
            input logic lvl);
        dma_active = act;
        dma_read = rd;
        tick();
        tick();
        check({output_enable_low_oe, output_enable_low_out}, {oe, lvl});
    endtask

    task automatic wrap_up();
        if (errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        wrap_up();
    end

    initial begin
        rstn = 1'b0;
        cs_n = 1'b1;
        we_n = 1'b1;
        output_enable_low_in = 1'b1;
        addr = 8'h00;
        data_in = 32'h0;
        test_mode = 1'b0;
        dma_active = 1'b0;
        dma_read = 1'b0;
        hs = 1'b1;
        repeat (10) tick();
        reset_check();
        for (int k = 0; k < 8; k++) begin
            test_mode = row_tm[k];
            access(1'b1, CTRL_OFS, {16'h0, row_w[k]}, q);
            check(outs, row_o[k]);
            access(1'b0, CTRL_OFS, 32'h0, q);
            check(q, {16'h0, row_rd[k]});
        end
        access(1'b0, IDENT_OFS, 32'h0, q);
        check(q, {ID, 8'h27});
        access(1'b1, IDENT_OFS, 32'hffff_ffff, q);
        access(1'b0, IDENT_OFS, 32'h0, q);
        check(q, {ID, 8'h27});
        access(1'b0, 8'h08, 32'h0, q);
        check(q, 32'h0);
        strobe(1'b1, 1'b1, 1'b1, 1'b0);
        strobe(1'b1, 1'b0, 1'b1, 1'b1);
        strobe(1'b0, 1'b0, 1'b0, 1'b1);
        access(1'b1, CTRL_OFS, 32'h0000_0080, q);
        strobe(1'b1, 1'b1, 1'b1, 1'b1);
        // A write while the device owns the bus must be ignored
        cs_n = 1'b0;
        we_n = 1'b0;
        data_in = 32'h0000_ffff;
        repeat (8) tick();
        check(rdy, 1'b1);
        cs_n = 1'b1;
        we_n = 1'b1;
        strobe(1'b0, 1'b0, 1'b0, 1'b1);
        access(1'b0, CTRL_OFS, 32'h0, q);
        check(q, 32'h0000_0080);
        access(1'b1, CTRL_OFS, 32'h0000_201f, q);
        rstn = 1'b0;
        tick();
        reset_check();
        wrap_up();
    end
endmodule
`default_nettype wire
